/* File: core/dapt_pkg.sv */
package dapt_pkg;
  // word indices on the avalon slave (byte address = 4 * index)
  localparam logic [2:0] DAPT_IDX_MODE = 3'h0;
  localparam logic [2:0] DAPT_IDX_PER_A = 3'h1;
  localparam logic [2:0] DAPT_IDX_PER_B = 3'h2;
  localparam logic [2:0] DAPT_IDX_ON_A = 3'h3;
  localparam logic [2:0] DAPT_IDX_ON_B = 3'h4;
  localparam logic [2:0] DAPT_IDX_PINSEL = 3'h5;
  localparam logic [2:0] DAPT_IDX_GPIOHI = 3'h6;
  localparam logic [2:0] DAPT_IDX_STATUS = 3'h7;
  // field positions
  localparam int DAPT_MODE_BIT = 8;
  localparam int DAPT_PIN_B_BIT = 7;
  localparam int DAPT_GPIOHI_SEL_BIT = 1;
  // reset values
  localparam logic DAPT_MODE_RST = 1'b0;
  localparam logic [7:0] DAPT_PER_RST = 8'hff;
  localparam logic [7:0] DAPT_ON_RST = 8'h00;
  localparam logic [7:0] DAPT_PINSEL_RST = 8'hff;
  localparam logic [1:0] DAPT_GPIOHI_RST = 2'h2;
  // time base: one unit is two core clocks
  localparam int DAPT_UNIT_CYCLES = 2;

  typedef struct packed {
    logic [2:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } dapt_req_type;

  typedef struct packed {
    logic mode_indep;
    logic [7:0] per_a;
    logic [7:0] per_b;
    logic [7:0] on_a;
    logic [7:0] on_b;
    logic [7:0] sh_a;
    logic [7:0] sh_b;
    logic [7:0] pin_sel;
    logic [1:0] gpio_hi;
    logic [7:0] cnt_a;
    logic [7:0] cnt_b;
    logic b_run;
    logic pre;
    logic out_a;
    logic out_b;
    logic pin_seven;
    logic pin_eight;
    logic rd_ack;
    logic [31:0] rdata;
  } dapt_state_type;
endpackage

/* File: core/dapt_top.sv */
`timescale 1ns/1ps
module dapt_top
  import dapt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic gpio_line_seven_out,
  input wire logic gpio_line_eight_out,
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic pin_line_seven,
  output logic pin_line_eight
);

  dapt_state_type s_q;
  dapt_state_type s_d;
  dapt_req_type req;
  logic wr_en;
  logic wr_per;
  logic tick;
  logic wrap_a;
  logic wrap_b;
  logic start_b;

  assign req = '{address: address, read: read, write: write, writedata: writedata};
  assign waitrequest = req.read & ~s_q.rd_ack;
  assign readdata = s_q.rdata;
  assign pwm_out_a = s_q.out_a;
  assign pwm_out_b = s_q.out_b;
  assign pin_line_seven = s_q.pin_seven;
  assign pin_line_eight = s_q.pin_eight;

  function automatic logic [31:0] read_mux(input dapt_state_type s, input logic [2:0] idx);
    logic [31:0] r;
    r = 32'h0;
    case (idx)
      DAPT_IDX_MODE: r[DAPT_MODE_BIT] = s.mode_indep;
      DAPT_IDX_PER_A: r[7:0] = s.per_a;
      DAPT_IDX_PER_B: r[7:0] = s.per_b;
      DAPT_IDX_ON_A: r[7:0] = s.on_a;
      DAPT_IDX_ON_B: r[7:0] = s.on_b;
      DAPT_IDX_PINSEL: r[7:0] = s.pin_sel;
      DAPT_IDX_GPIOHI: r[1:0] = s.gpio_hi;
      DAPT_IDX_STATUS: r = {12'h0, s.b_run, s.out_b, s.out_a, s.pre, s.cnt_b, s.cnt_a};
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  function automatic logic is_idx(input dapt_req_type r, input logic [2:0] idx);
    return r.write && (r.address == idx);
  endfunction

  always_comb begin
    s_d = s_q;
    wr_en = req.write & ~req.read;
    wr_per = wr_en && (is_idx(req, DAPT_IDX_PER_A) || is_idx(req, DAPT_IDX_PER_B));
    // one unit every DAPT_UNIT_CYCLES clocks
    tick = s_q.pre;
    wrap_a = tick && (s_q.cnt_a == s_q.per_a);
    wrap_b = tick && (s_q.cnt_b == s_q.per_b);
    // offset mode: second output starts when first reaches offset plus one units
    start_b = tick && !wrap_a && (s_q.cnt_a == s_q.per_b);
    // register writes
    if (wr_en) begin
      if (is_idx(req, DAPT_IDX_MODE)) begin
        s_d.mode_indep = req.writedata[DAPT_MODE_BIT];
      end
      if (is_idx(req, DAPT_IDX_PER_A)) begin
        s_d.per_a = req.writedata[7:0];
      end
      if (is_idx(req, DAPT_IDX_PER_B)) begin
        s_d.per_b = req.writedata[7:0];
      end
      if (is_idx(req, DAPT_IDX_ON_A)) begin
        s_d.on_a = req.writedata[7:0];
      end
      if (is_idx(req, DAPT_IDX_ON_B)) begin
        s_d.on_b = req.writedata[7:0];
      end
      if (is_idx(req, DAPT_IDX_PINSEL)) begin
        s_d.pin_sel = req.writedata[7:0];
      end
      if (is_idx(req, DAPT_IDX_GPIOHI)) begin
        s_d.gpio_hi = req.writedata[1:0];
      end
    end
    // time base and counters
    if (wr_per) begin
      s_d.pre = 1'b0;
      s_d.cnt_a = 8'h00;
      s_d.cnt_b = 8'h00;
      s_d.sh_a = s_d.on_a;
      s_d.sh_b = s_d.on_b;
      s_d.b_run = s_q.mode_indep;
    end else begin
      s_d.pre = ~s_q.pre;
      if (wrap_a) begin
        s_d.cnt_a = 8'h00;
        s_d.sh_a = s_q.on_a;
      end else if (tick) begin
        s_d.cnt_a = s_q.cnt_a + 8'h01;
      end
      if (s_q.mode_indep) begin
        s_d.b_run = 1'b1;
        if (wrap_b) begin
          s_d.cnt_b = 8'h00;
          s_d.sh_b = s_q.on_b;
        end else if (tick) begin
          s_d.cnt_b = s_q.cnt_b + 8'h01;
        end
      end else begin
        // shared period: second counter restarts once per first-counter cycle if per_b is below per_a
        if (start_b) begin
          s_d.cnt_b = 8'h00;
          s_d.sh_b = s_q.on_b;
          s_d.b_run = 1'b1;
        end else if (tick && s_q.cnt_b != 8'hff) begin
          s_d.cnt_b = s_q.cnt_b + 8'h01;
        end
      end
    end
    // outputs high for on-time units from cycle start; over-range is always high except output b in offset mode, output b only once b_run is set
    s_d.out_a = s_d.cnt_a < s_d.sh_a;
    s_d.out_b = s_d.b_run && (s_d.cnt_b < s_d.sh_b);
    // pin multiplexing
    s_d.pin_seven = s_q.pin_sel[DAPT_PIN_B_BIT] ? gpio_line_seven_out : s_q.out_b;
    s_d.pin_eight = s_q.gpio_hi[DAPT_GPIOHI_SEL_BIT] ? gpio_line_eight_out : s_q.out_a;
    // avalon read: one wait cycle, data registered
    if (s_q.rd_ack) begin
      s_d.rd_ack = 1'b0;
    end else if (req.read) begin
      s_d.rd_ack = 1'b1;
      s_d.rdata = read_mux(s_q, req.address);
    end
    if (srst) begin
      s_d = '0;
      s_d.mode_indep = DAPT_MODE_RST;
      s_d.per_a = DAPT_PER_RST;
      s_d.per_b = DAPT_PER_RST;
      s_d.on_a = DAPT_ON_RST;
      s_d.on_b = DAPT_ON_RST;
      s_d.sh_a = DAPT_ON_RST;
      s_d.sh_b = DAPT_ON_RST;
      s_d.pin_sel = DAPT_PINSEL_RST;
      s_d.gpio_hi = DAPT_GPIOHI_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  logic past_srst;
  always_ff @(posedge clk_sys) begin
    past_srst <= srst;
  end

  sequence per_write_s;
    write && !read && (address == DAPT_IDX_PER_A || address == DAPT_IDX_PER_B);
  endsequence

  sequence restart_s;
    s_q.cnt_a == 8'h00 && s_q.cnt_b == 8'h00 && !s_q.pre;
  endsequence

  reset_defaults_a: assert property (@(posedge clk_sys) past_srst && !srst |->
    !s_q.mode_indep && s_q.per_a == 8'hff && s_q.per_b == 8'hff && s_q.on_a == 8'h00
    && s_q.on_b == 8'h00 && s_q.pin_sel == 8'hff && s_q.gpio_hi == DAPT_GPIOHI_RST)
    else $error("register defaults wrong after reset");

  period_restart_a: assert property (per_write_s |=> restart_s)
    else $error("period write did not restart timers");

  zero_duty_a: assert property (s_q.sh_a == 8'h00 |-> !pwm_out_a)
    else $error("output a high with zero on-time");

  full_duty_a: assert property (s_q.sh_b > s_q.per_b && s_q.mode_indep && s_q.b_run |-> pwm_out_b)
    else $error("output b not full duty with over-range on-time");

  period_len_a: assert property (tick && s_q.cnt_a == 8'h00 && s_q.per_a == 8'h02 ##1 !$past(wr_per)
    |-> ##[5:5] (s_q.cnt_a == 8'h00 || $past(wr_per, 5)))
    else $error("period of output a not two clocks times value plus one");

  shadow_hold_a: assert property (!wrap_a && !wr_per |=> $stable(s_q.sh_a))
    else $error("on-time of output a changed inside a cycle");

  indep_wrap_a: assert property (s_q.mode_indep && wrap_b && !wr_per |=> s_q.cnt_b == 8'h00)
    else $error("independent output b did not wrap at own period");

  offset_start_a: assert property (!s_q.mode_indep && start_b && !wr_per |=> s_q.cnt_b == 8'h00
    && s_q.b_run)
    else $error("offset output b did not start at offset");

  pin_mux_a: assert property (!s_q.pin_sel[DAPT_PIN_B_BIT] |=> pin_line_seven == $past(s_q.out_b))
    else $error("pin seven not routed to pwm output b");

  pin_eight_a: assert property (!s_q.gpio_hi[DAPT_GPIOHI_SEL_BIT] |=> pin_line_eight == $past(s_q.out_a))
    else $error("pin eight not routed to pwm output a");

  rise_start_a: assert property (wrap_a && !wr_per && s_q.on_a != 8'h00 |=> pwm_out_a)
    else $error("output a did not rise at cycle start");

  read_answer_a: assert property (read && waitrequest |=> !waitrequest || !read)
    else $error("read not answered in one wait cycle");

  sequence read_wait_s;
    read && waitrequest;
  endsequence

  sequence offset_start_s;
    !s_q.mode_indep && start_b && !wr_per;
  endsequence

  sequence wrap_a_s;
    wrap_a && !wr_per;
  endsequence

  sequence on_a_write_s;
    write && !read && address == DAPT_IDX_ON_A;
  endsequence

  a_counter_wrap_a: assert property (wrap_a_s
    |=> s_q.cnt_a == 8'h00)
    else $error("output a counter did not wrap at its period");

  zero_duty_b_a: assert property (s_q.sh_b == 8'h00
    |-> !pwm_out_b)
    else $error("output b high with zero on-time");

  full_duty_out_a: assert property (s_q.sh_a > s_q.per_a
    |-> pwm_out_a)
    else $error("output a not full duty with over-range on-time");

  offset_b_idle_a: assert property (!s_q.mode_indep && !s_q.b_run
    |-> !pwm_out_b)
    else $error("output b high before its first offset start");

  prescale_toggle_a: assert property (!wr_per
    |=> s_q.pre != $past(s_q.pre))
    else $error("time base unit is not two clocks");

  on_write_hold_a: assert property (on_a_write_s ##0 !wrap_a
    |=> s_q.sh_a == $past(s_q.sh_a))
    else $error("on-time write changed the running cycle");

  shadow_load_a: assert property (wrap_a_s
    |=> s_q.sh_a == $past(s_q.on_a))
    else $error("new on-time not taken at cycle start");

  restart_shadow_a: assert property (per_write_s
    |=> s_q.sh_a == $past(s_d.on_a))
    else $error("period write did not load on-time for new cycle");

  mode_write_a: assert property (write && !read && address == DAPT_IDX_MODE
    |=> s_q.mode_indep == $past(writedata[DAPT_MODE_BIT]))
    else $error("mode bit not taken from write data");

  offset_rise_b_a: assert property (offset_start_s ##0 s_q.on_b != 8'h00
    |=> pwm_out_b)
    else $error("output b did not rise at offset");

  pin_seven_gpio_a: assert property (s_q.pin_sel[DAPT_PIN_B_BIT]
    |=> pin_line_seven == $past(gpio_line_seven_out))
    else $error("pin seven not routed to gpio");

  pin_eight_gpio_a: assert property (s_q.gpio_hi[DAPT_GPIOHI_SEL_BIT]
    |=> pin_line_eight == $past(gpio_line_eight_out))
    else $error("pin eight not routed to gpio");

  write_no_wait_a: assert property (write && !read
    |-> !waitrequest)
    else $error("write was made to wait");

  on_time_end_a: assert property (s_q.cnt_a >= s_q.sh_a
    |-> !pwm_out_a)
    else $error("output a high after its on-time");

  b_saturate_a: assert property (!s_q.mode_indep && s_q.cnt_b == 8'hff && !start_b && !wr_per
    |=> s_q.cnt_b == 8'hff)
    else $error("offset counter b left saturation without a start");

  read_data_a: assert property (read_wait_s ##0 address == DAPT_IDX_PER_A
    |=> readdata[7:0] == $past(s_q.per_a))
    else $error("read data of period a wrong");

  b_indep_run_a: assert property (s_q.mode_indep && !wr_per
    |=> s_q.b_run)
    else $error("independent output b not running");

  read_ack_drop_a: assert property (s_q.rd_ack
    |=> !s_q.rd_ack)
    else $error("read acknowledge held longer than one cycle");

endmodule

/* File: verif/dapt_load_model.sv */
`timescale 1ns/1ps
// load on a pwm pin: times period, high time and last rise in core clocks
module dapt_load_model (
  input wire logic clk_sys,
  input wire logic pin_level,
  output int period_q,
  output int high_q,
  output int rise_q
);
  int cyc = 0;
  logic last = 1'b0;
  initial begin
    period_q = 0;
    high_q = 0;
    rise_q = 0;
  end
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    last <= pin_level;
    if (pin_level && !last) begin
      period_q <= cyc - rise_q;
      rise_q <= cyc;
    end
    if (!pin_level && last) high_q <= cyc - rise_q;
  end
endmodule

/* File: verif/dual_aux_pwm_timer_tb.sv */
`timescale 1ns/1ps
module dual_aux_pwm_timer_tb
  import dapt_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [2:0] address = 3'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic gpio_in = 1'b1;
  logic [31:0] readdata, rv;
  logic waitrequest, pwm_out_a, pwm_out_b, pin_line_seven, pin_line_eight;
  int num_errors = 0;
  int checked = 0;
  int pa, ha, ra, pb, hb, rb, c;
  logic [31:0] rst_exp [7];
  always #5 clk_sys = ~clk_sys;
  dapt_top dapt_top_i (.clk_sys(clk_sys), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .gpio_line_seven_out(gpio_in),
    .gpio_line_eight_out(gpio_in), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
    .pin_line_seven(pin_line_seven), .pin_line_eight(pin_line_eight));
  dapt_load_model dapt_load_model_a_i (.clk_sys(clk_sys), .pin_level(pin_line_eight), .period_q(pa),
    .high_q(ha), .rise_q(ra));
  dapt_load_model dapt_load_model_b_i (.clk_sys(clk_sys), .pin_level(pin_line_seven), .period_q(pb),
    .high_q(hb), .rise_q(rb));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic av(input logic rd, input logic [2:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    address <= idx;
    writedata <= wd;
    read <= rd;
    write <= !rd;
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'b0);
    rv = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] idx, input logic [31:0] wd);
    av(1'b0, idx, wd);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic count_a(input logic lvl);
    c = 0;
    repeat (40) begin
      @(negedge clk_sys);
      if (pwm_out_a === lvl) c++;
    end
  endtask
  initial begin
    settle(5000);
    num_errors++;
    complete_run();
  end
  initial begin
    rst_exp = '{{23'h0, DAPT_MODE_RST, 8'h0}, {24'h0, DAPT_PER_RST}, {24'h0, DAPT_PER_RST},
      {24'h0, DAPT_ON_RST}, {24'h0, DAPT_ON_RST}, {24'h0, DAPT_PINSEL_RST}, {30'h0, DAPT_GPIOHI_RST}};
    settle(5);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      av(1'b1, 3'(i), 32'h0);
      chk("reset value", rst_exp[i], rv);
    end
    @(negedge clk_sys);
    chk("pin seven gpio", 32'h1, {31'h0, pin_line_seven});
    chk("pin eight gpio", 32'h1, {31'h0, pin_line_eight});
    @(posedge clk_sys);
    gpio_in <= 1'b0;
    settle(2);
    @(negedge clk_sys);
    chk("pin seven gpio low", 32'h0, {31'h0, pin_line_seven});
    chk("pin eight gpio low", 32'h0, {31'h0, pin_line_eight});
    wr(DAPT_IDX_PINSEL, 32'h7f);
    wr(DAPT_IDX_GPIOHI, 32'h0);
    wr(DAPT_IDX_MODE, 32'h100);
    wr(DAPT_IDX_PER_A, 32'h9);
    wr(DAPT_IDX_PER_B, 32'h4);
    wr(DAPT_IDX_ON_A, 32'h3);
    wr(DAPT_IDX_ON_B, 32'h2);
    settle(80);
    chk("period a", 32'd20, pa);
    chk("high a", 32'd6, ha);
    chk("period b", 32'd10, pb);
    chk("high b", 32'd4, hb);
    wr(DAPT_IDX_ON_A, 32'h20);
    settle(25);
    count_a(1'b1);
    chk("full duty", 32'd40, c);
    wr(DAPT_IDX_ON_A, 32'h0);
    settle(25);
    count_a(1'b1);
    chk("zero duty", 32'd0, c);
    wr(DAPT_IDX_MODE, 32'h0);
    wr(DAPT_IDX_ON_A, 32'h2);
    wr(DAPT_IDX_PER_B, 32'h3);
    settle(80);
    chk("shared period", 32'd20, pb);
    chk("offset", 32'd8, ((rb - ra) % 20 + 20) % 20);
    c = 0;
    while (pwm_out_a !== 1'b1 && c < 50) begin
      @(negedge clk_sys);
      c++;
    end
    while (pwm_out_a !== 1'b0 && c < 50) begin
      @(negedge clk_sys);
      c++;
    end
    wr(DAPT_IDX_PER_A, 32'h9);
    @(negedge clk_sys);
    chk("restart rise", 32'h1, {31'h0, pwm_out_a});
    wr(DAPT_IDX_ON_A, 32'h6);
    settle(10);
    chk("running on-time", 32'd4, ha);
    settle(30);
    chk("next on-time", 32'd12, ha);
    complete_run();
  end
endmodule
